// ===== change_flag_bank.sv
// sticky change-capture bank for one interrupt source group
// assumes status input is already synchronous to core_clk
module change_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk, // register clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] status, // current condition bits
  input wire logic [WIDTH-1:0] enable, // per-bit enable
  input wire logic clear, // read-to-clear strobe
  output logic [WIDTH-1:0] flags // accumulated change flags
);

  logic [WIDTH-1:0] status_q;
  logic [WIDTH-1:0] next_status_q;
  logic [WIDTH-1:0] next_flags;

  always_comb begin
    next_status_q = status;
    // new change beats a clearing read in the same cycle
    next_flags = (clear ? '0 : flags) | ((status ^ status_q) & enable);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      flags <= '0;
    end else begin
      status_q <= next_status_q;
      flags <= next_flags;
    end
  end

endmodule : change_flag_bank

// ===== pulse_shape_access_alarm_irq.sv
// register bank: alarm change interrupts and custom pulse sample access
// assumes a synchronous 8-bit host port on core_clk; alarm status synchronous
// rst_n clears everything, soft_reset clears registers and flags but keeps sample memory and read data
//
// Behaviour
// - alarm enable bit n lets channel n alarm changes reach flags and pin.
// - alarm change flag n sets when alarm status bit n changes.
// - alarm change flags accumulate until cleared.
// - reading an interrupt flag register clears it; the pin releases once neither register holds an enabled flag.
// - enable, flag, broadcast, pointer and source registers reset to 00h.
// - set broadcast bits make a sample write hit all masked channels together.
// - pointer bits 7:5 choose the channel for sample access.
// - pointer bits 4:0 choose the phase slot within the channel.
// - sample write stores low seven bits; read returns addressed slot.
// - software reset keeps sample contents; only power-up clears them.
// - samples are seven-bit two's complement, 3Fh max, 40h min.
// - source bit one selects custom samples for that channel.
// - source bit zero selects the built-in shape for that channel.
// - overflow enable bit n lets channel n overflow changes reach flags and pin.
// - overflow when first plus tail interval sample leaves seven-bit range.
// - clearing an enable blocks both flag capture and the interrupt, status still tracks.
module pulse_shape_access_alarm_irq #(
  parameter int CHANNELS = pulse_shape_pkg::NUM_CHANNELS,
  parameter int SLOTS = pulse_shape_pkg::NUM_SLOTS
) (
  input wire logic core_clk, // register clock, 25 MHz
  input wire logic rst_n, // power-up reset, async, active low
  input wire logic soft_reset, // software reset request, one cycle
  input wire pulse_shape_pkg::host_req_t host_req, // host register access
  input wire logic [CHANNELS-1:0] all_ones_alarm, // per-channel alarm status
  output logic [7:0] host_rdata, // read data, valid cycle after rd
  output logic irq_n, // interrupt request, active low
  output logic [CHANNELS-1:0] custom_shape_select, // 1 = custom samples
  output logic [CHANNELS-1:0] overflow_status, // per-channel overflow now
  output logic [CHANNELS*SLOTS*pulse_shape_pkg::SAMPLE_BITS-1:0] sample_image // all samples
);

  localparam int SB = pulse_shape_pkg::SAMPLE_BITS;
  localparam int CB = pulse_shape_pkg::CHAN_BITS;
  localparam int LB = pulse_shape_pkg::SLOT_BITS;

  // ==========================================================
  // control registers
  logic [7:0] alarm_irq_enable;
  logic [7:0] shape_broadcast_mask;
  logic [7:0] shape_sample_pointer;
  logic [7:0] shape_source_select;
  logic [7:0] shape_overflow_irq_enable;
  logic [7:0] next_alarm_irq_enable;
  logic [7:0] next_shape_broadcast_mask;
  logic [7:0] next_shape_sample_pointer;
  logic [7:0] next_shape_source_select;
  logic [7:0] next_shape_overflow_irq_enable;

  logic wr_hit;
  assign wr_hit = host_req.wr;

  // software reset wins over a write in the same cycle
  always_comb begin
    next_alarm_irq_enable = alarm_irq_enable;
    next_shape_broadcast_mask = shape_broadcast_mask;
    next_shape_sample_pointer = shape_sample_pointer;
    next_shape_source_select = shape_source_select;
    next_shape_overflow_irq_enable = shape_overflow_irq_enable;
    if (soft_reset) begin
      next_alarm_irq_enable = pulse_shape_pkg::REG_RESET;
      next_shape_broadcast_mask = pulse_shape_pkg::REG_RESET;
      next_shape_sample_pointer = pulse_shape_pkg::REG_RESET;
      next_shape_source_select = pulse_shape_pkg::REG_RESET;
      next_shape_overflow_irq_enable = pulse_shape_pkg::REG_RESET;
    end else if (wr_hit) begin
      unique case (host_req.addr)
        pulse_shape_pkg::ADDR_ALARM_IRQ_ENABLE: begin
          next_alarm_irq_enable = host_req.wdata;
        end
        pulse_shape_pkg::ADDR_SHAPE_BROADCAST_MASK: begin
          next_shape_broadcast_mask = host_req.wdata;
        end
        pulse_shape_pkg::ADDR_SHAPE_SAMPLE_POINTER: begin
          next_shape_sample_pointer = host_req.wdata;
        end
        pulse_shape_pkg::ADDR_SHAPE_SOURCE_SELECT: begin
          next_shape_source_select = host_req.wdata;
        end
        pulse_shape_pkg::ADDR_SHAPE_OVERFLOW_IRQ_ENABLE: begin
          next_shape_overflow_irq_enable = host_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_irq_enable <= pulse_shape_pkg::REG_RESET;
      shape_broadcast_mask <= pulse_shape_pkg::REG_RESET;
      shape_sample_pointer <= pulse_shape_pkg::REG_RESET;
      shape_source_select <= pulse_shape_pkg::REG_RESET;
      shape_overflow_irq_enable <= pulse_shape_pkg::REG_RESET;
    end else begin
      alarm_irq_enable <= next_alarm_irq_enable;
      shape_broadcast_mask <= next_shape_broadcast_mask;
      shape_sample_pointer <= next_shape_sample_pointer;
      shape_source_select <= next_shape_source_select;
      shape_overflow_irq_enable <= next_shape_overflow_irq_enable;
    end
  end

  // ==========================================================
  // sample memory: power-up reset only, software reset leaves it
  logic [SB-1:0] sample_mem [CHANNELS][SLOTS];
  logic [SB-1:0] next_sample_mem [CHANNELS][SLOTS];
  logic [CB-1:0] target_channel_field;
  logic [LB-1:0] phase_slot_index;
  logic sample_wr;
  logic [CHANNELS-1:0] chan_wr;

  assign target_channel_field = shape_sample_pointer[pulse_shape_pkg::PTR_CHAN_LSB +: CB];
  assign phase_slot_index = shape_sample_pointer[pulse_shape_pkg::PTR_SLOT_LSB +: LB];
  assign sample_wr = wr_hit && (host_req.addr == pulse_shape_pkg::ADDR_SHAPE_SAMPLE_VALUE);

  // broadcast overrides the pointer channel when any mask bit is set
  always_comb begin
    chan_wr = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (shape_broadcast_mask != 8'h00) begin
        chan_wr[c] = sample_wr && shape_broadcast_mask[c];
      end else begin
        chan_wr[c] = sample_wr && (target_channel_field == CB'(c));
      end
    end
  end

  // slots beyond the mode's count are stored as well; the host keeps clear of them
  always_comb begin
    next_sample_mem = sample_mem;
    for (int c = 0; c < CHANNELS; c++) begin
      if (chan_wr[c]) begin
        // bit 7 dropped; host keeps it zero
        next_sample_mem[c][phase_slot_index] = host_req.wdata[SB-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int s = 0; s < SLOTS; s++) begin
          sample_mem[c][s] <= '0;
        end
      end
    end else begin
      sample_mem <= next_sample_mem;
    end
  end

  // ==========================================================
  // overflow detection and interrupt flag banks
  logic [CHANNELS-1:0] next_overflow_status;
  logic [7:0] alarm_irq_change_flags;
  logic [7:0] shape_overflow_irq_flags;
  logic rd_alarm_flags;
  logic rd_ovf_flags;

  // a flag register read clears at the same edge that captures its data
  assign rd_alarm_flags = host_req.rd &&
                          (host_req.addr == pulse_shape_pkg::ADDR_ALARM_IRQ_CHANGE_FLAGS);
  assign rd_ovf_flags = host_req.rd &&
                        (host_req.addr == pulse_shape_pkg::ADDR_SHAPE_OVERFLOW_IRQ_FLAGS);

  // tail base fixed at slot 14; shorter modes must keep unused slots zero
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ovf
      logic [SLOTS*SB-1:0] flat;
      always_comb begin
        flat = '0;
        for (int s = 0; s < SLOTS; s++) begin
          flat[s*SB +: SB] = sample_mem[g][s];
        end
        sample_image[(g*SLOTS+0)*SB +: SLOTS*SB] = flat;
      end
      sample_overflow_check #(
        .SLOTS(SLOTS),
        .UI_SLOTS(pulse_shape_pkg::FIRST_UI_SLOTS),
        .BITS(SB)
      ) u_check (
        .samples(flat),
        .overflow(next_overflow_status[g])
      );
    end
  endgenerate

  // registered so the status output and the change detector see a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_status <= '0;
    end else begin
      overflow_status <= next_overflow_status;
    end
  end

  // a change in the same cycle as a clearing read survives the read
  change_flag_bank #(.WIDTH(8)) u_alarm_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .status(8'(all_ones_alarm)),
    .enable(alarm_irq_enable),
    .clear(rd_alarm_flags || soft_reset),
    .flags(alarm_irq_change_flags)
  );

  change_flag_bank #(.WIDTH(8)) u_ovf_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .status(8'(overflow_status)),
    .enable(shape_overflow_irq_enable),
    .clear(rd_ovf_flags || soft_reset),
    .flags(shape_overflow_irq_flags)
  );

  // ==========================================================
  // interrupt pin
  logic next_irq_n;

  always_comb begin
    // enable gates flag capture and the pin; overflow_status keeps tracking regardless
    next_irq_n = !(|(alarm_irq_change_flags & alarm_irq_enable) ||
                   |(shape_overflow_irq_flags & shape_overflow_irq_enable));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= next_irq_n;
    end
  end

  // ==========================================================
  // source select, registered so the transmit side sees a flop
  logic [CHANNELS-1:0] next_custom_shape_select;

  always_comb begin
    next_custom_shape_select = shape_source_select[CHANNELS-1:0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      custom_shape_select <= '0;
    end else begin
      custom_shape_select <= next_custom_shape_select;
    end
  end

  // ==========================================================
  // read data: held until the next read, pointer taken as it stands
  logic [7:0] next_host_rdata;

  always_comb begin
    next_host_rdata = host_rdata;
    if (host_req.rd) begin
      unique case (host_req.addr)
        pulse_shape_pkg::ADDR_ALARM_IRQ_ENABLE: begin
          next_host_rdata = alarm_irq_enable;
        end
        pulse_shape_pkg::ADDR_ALARM_IRQ_CHANGE_FLAGS: begin
          next_host_rdata = alarm_irq_change_flags;
        end
        pulse_shape_pkg::ADDR_SHAPE_BROADCAST_MASK: begin
          next_host_rdata = shape_broadcast_mask;
        end
        pulse_shape_pkg::ADDR_SHAPE_SAMPLE_POINTER: begin
          next_host_rdata = shape_sample_pointer;
        end
        pulse_shape_pkg::ADDR_SHAPE_SAMPLE_VALUE: begin
          next_host_rdata = {1'b0, sample_mem[target_channel_field][phase_slot_index]};
        end
        pulse_shape_pkg::ADDR_SHAPE_SOURCE_SELECT: begin
          next_host_rdata = shape_source_select;
        end
        pulse_shape_pkg::ADDR_SHAPE_OVERFLOW_IRQ_ENABLE: begin
          next_host_rdata = shape_overflow_irq_enable;
        end
        pulse_shape_pkg::ADDR_SHAPE_OVERFLOW_IRQ_FLAGS: begin
          next_host_rdata = shape_overflow_irq_flags;
        end
        default: begin
          next_host_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
    end else begin
      host_rdata <= next_host_rdata;
    end
  end

endmodule : pulse_shape_access_alarm_irq

// ===== pulse_shape_access_alarm_irq_properties.sv
// checker: port-level properties of the pulse-shape register bank
// assumes the package is compiled first; bound to every bank instance
module pulse_shape_access_alarm_irq_properties #(
  parameter int CHANNELS = 8,
  parameter int SLOTS = 32
) (
  input wire logic core_clk, // register clock
  input wire logic rst_n, // async reset, active low
  input wire logic soft_reset, // software reset pulse
  input wire pulse_shape_pkg::host_req_t host_req, // host access
  input wire logic [CHANNELS-1:0] all_ones_alarm, // alarm status
  input wire logic [7:0] host_rdata, // read data
  input wire logic irq_n, // interrupt, active low
  input wire logic [CHANNELS-1:0] custom_shape_select, // source select
  input wire logic [CHANNELS-1:0] overflow_status, // overflow now
  input wire logic [CHANNELS*SLOTS*pulse_shape_pkg::SAMPLE_BITS-1:0] sample_image // samples
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper logic
  wire src_wr = host_req.wr && host_req.addr == pulse_shape_pkg::ADDR_SHAPE_SOURCE_SELECT;
  wire smp_wr = host_req.wr && host_req.addr == pulse_shape_pkg::ADDR_SHAPE_SAMPLE_VALUE;
  wire smp_rd = host_req.rd && host_req.addr == pulse_shape_pkg::ADDR_SHAPE_SAMPLE_VALUE;
  wire far_rd = host_req.rd && (host_req.addr < 8'h14 || host_req.addr > 8'h1B);
  // an enable write can raise the pin over a flag that is already set
  wire en_wr = host_req.wr &&
    (host_req.addr == pulse_shape_pkg::ADDR_ALARM_IRQ_ENABLE ||
     host_req.addr == pulse_shape_pkg::ADDR_SHAPE_OVERFLOW_IRQ_ENABLE);
  logic [2:0] quiet; // saturating count since a cause moved
  logic [CHANNELS-1:0] last_alarm;
  logic [CHANNELS-1:0] last_ovf;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 3'h7;
      last_alarm <= '0;
      last_ovf <= '0;
    end else begin
      last_alarm <= all_ones_alarm;
      last_ovf <= overflow_status;
      if (en_wr || all_ones_alarm != last_alarm || overflow_status != last_ovf) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  rdata_on_read_a: assert property ($changed(host_rdata) |-> $past(host_req.rd))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (far_rd |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  sample_top_bit_a: assert property (smp_rd |=> !host_rdata[7])
    else $error("sample read bit 7 set");
  source_cause_a: assert property ($changed(custom_shape_select) |->
    $past(src_wr) || $past(src_wr, 2) || $past(soft_reset) || $past(soft_reset, 2))
    else $error("source select moved without cause");
  irq_cause_a: assert property ($fell(irq_n) |-> quiet <= 3'h5)
    else $error("interrupt without status change");
  reset_values_a: assert property ($rose(rst_n) |->
    irq_n && custom_shape_select == '0 && host_rdata == 8'h00)
    else $error("outputs not at reset value");
  soft_clear_a: assert property (soft_reset && !host_req.wr |->
    ##[1:2] custom_shape_select == '0)
    else $error("soft reset left source select");
  sample_keep_a: assert property (soft_reset && !host_req.wr |=> $stable(sample_image))
    else $error("soft reset changed samples");
  sample_cause_a: assert property ($changed(sample_image) |-> $past(smp_wr))
    else $error("samples moved without a write");
  cover property (smp_wr && host_req.wdata == 8'h40);
  cover property ($fell(irq_n));
  cover property (soft_reset);
  cover property (overflow_status != '0);
endmodule : pulse_shape_access_alarm_irq_properties

bind pulse_shape_access_alarm_irq pulse_shape_access_alarm_irq_properties #(
  .CHANNELS(CHANNELS), .SLOTS(SLOTS)) props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset), .host_req(host_req),
  .all_ones_alarm(all_ones_alarm), .host_rdata(host_rdata), .irq_n(irq_n),
  .custom_shape_select(custom_shape_select), .overflow_status(overflow_status),
  .sample_image(sample_image));

// ===== pulse_shape_pkg.sv
// package for the pulse-shape access and alarm interrupt register bank
// assumes an 8-bit host register port with byte-wide offsets
package pulse_shape_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_ALARM_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_ALARM_IRQ_CHANGE_FLAGS = 8'h15;
  localparam logic [7:0] ADDR_SHAPE_BROADCAST_MASK = 8'h16;
  localparam logic [7:0] ADDR_SHAPE_SAMPLE_POINTER = 8'h17;
  localparam logic [7:0] ADDR_SHAPE_SAMPLE_VALUE = 8'h18;
  localparam logic [7:0] ADDR_SHAPE_SOURCE_SELECT = 8'h19;
  localparam logic [7:0] ADDR_SHAPE_OVERFLOW_IRQ_ENABLE = 8'h1A;
  localparam logic [7:0] ADDR_SHAPE_OVERFLOW_IRQ_FLAGS = 8'h1B;

  // ==========================================================
  // field layout and reset values
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_SLOTS = 32;
  localparam int SLOT_BITS = 5;
  localparam int CHAN_BITS = 3;
  localparam int SAMPLE_BITS = 7;
  localparam int PTR_CHAN_LSB = 5;
  localparam int PTR_SLOT_LSB = 0;
  localparam int FIRST_UI_SLOTS = 14;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] SAMPLE_MAX_POS = 7'h3F;
  localparam logic [6:0] SAMPLE_MAX_NEG = 7'h40;

  // ==========================================================
  // host port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

endpackage : pulse_shape_pkg

// ===== sample_overflow_check.sv
// per-channel overflow detector over first and tail interval samples
// assumes memory image is presented flat, slot 0 in the low bits
module sample_overflow_check #(
  parameter int SLOTS = 32,
  parameter int UI_SLOTS = 14,
  parameter int BITS = 7
) (
  input wire logic [SLOTS*BITS-1:0] samples, // one channel's sample memory
  output logic overflow // some slot pair sum leaves range
);

  always_comb begin
    logic [BITS:0] sum;
    logic [BITS-1:0] a;
    logic [BITS-1:0] b;
    sum = '0;
    a = '0;
    b = '0;
    overflow = 1'b0;
    for (int i = 0; i < UI_SLOTS; i++) begin
      a = samples[i*BITS +: BITS];
      b = samples[(i+UI_SLOTS)*BITS +: BITS];
      // sign-extended add; top two bits disagree on overflow
      sum = {a[BITS-1], a} + {b[BITS-1], b};
      if (sum[BITS] != sum[BITS-1]) begin
        overflow = 1'b1;
      end
    end
  end

endmodule : sample_overflow_check

// ===== test_pulse_shape_access_alarm_irq.sv
// self-checking bench for the pulse-shape register bank over its host port
// assumes package, design and checker files are compiled before it
module test_pulse_shape_access_alarm_irq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SL = pulse_shape_pkg::NUM_SLOTS;
  localparam logic [7:0] BC_MASK = 8'hA5;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  pulse_shape_pkg::host_req_t host_req = '0;
  logic [7:0] all_ones_alarm = 8'h00;
  logic [7:0] host_rdata;
  logic irq_n;
  logic [7:0] custom_shape_select;
  logic [7:0] overflow_status;
  logic [8*SL*7-1:0] sample_image;
  logic [7:0] rd;
  logic [7:0] rw_addr [5] = '{8'h14, 8'h16, 8'h17, 8'h19, 8'h1A};
  int error_cnt = 0;
  int compares = 0;
  pulse_shape_access_alarm_irq pulse_shape_access_alarm_irq_inst (
    .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset), .host_req(host_req),
    .all_ones_alarm(all_ones_alarm), .host_rdata(host_rdata), .irq_n(irq_n),
    .custom_shape_select(custom_shape_select), .overflow_status(overflow_status),
    .sample_image(sample_image));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================================
  // tasks
  task automatic close_out();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  // strobe lowered then one spare edge, so no signal is set twice at one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_req.wr <= 1'b1;
    host_req.addr <= a;
    host_req.wdata <= d;
    idle(1);
    host_req.wr <= 1'b0;
    idle(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    host_req.rd <= 1'b1;
    host_req.addr <= a;
    idle(1);
    host_req.rd <= 1'b0;
    idle(1);
    d = host_rdata;
  endtask : rd_reg
  task automatic put(input int c, input int s, input logic [7:0] d);
    wr_reg(8'h17, {3'(c), 5'(s)});
    wr_reg(8'h18, d);
  endtask : put
  function automatic logic [7:0] img(input int c, input int s);
    return {1'b0, sample_image[(c*SL+s)*7 +: 7]};
  endfunction : img
  // ==========================================================
  // watchdog, the whole sequence needs well under a thousand cycles
  initial begin
    idle(3000);
    error_cnt++;
    close_out();
  end
  // ==========================================================
  // tests
  initial begin
    idle(12);
    rst_n <= 1'b1;
    for (int a = 8'h10; a <= 8'h1D; a++) begin
      rd_reg(8'(a), rd);
      cmp8(rd, 8'h00);
    end
    cmp8({7'h0, irq_n}, 8'h01);
    put(1, 2, 8'h3F);
    put(6, 23, 8'h40);
    rd_reg(8'h18, rd);
    cmp8(rd, 8'h40);
    cmp8(img(1, 2), 8'h3F);
    cmp8(img(6, 23), 8'h40);
    cmp8(img(6, 2), 8'h00);
    cmp8(img(1, 23), 8'h00);
    wr_reg(8'h17, 8'h22);
    rd_reg(8'h18, rd);
    cmp8(rd, 8'h3F);
    wr_reg(8'h16, BC_MASK);
    put(1, 3, 8'h15);
    for (int c = 0; c < 8; c++) cmp8(img(c, 3), BC_MASK[c] ? 8'h15 : 8'h00);
    wr_reg(8'h16, 8'h00);
    // overflow with its enable off: status moves, nothing recorded
    put(3, 0, 8'h3F);
    put(3, 14, 8'h01);
    idle(3);
    cmp8(overflow_status, 8'h08);
    cmp8({7'h0, irq_n}, 8'h01);
    rd_reg(8'h1B, rd);
    cmp8(rd, 8'h00);
    wr_reg(8'h1A, 8'h08);
    put(3, 14, 8'h00);
    idle(4);
    cmp8(overflow_status, 8'h00);
    cmp8({7'h0, irq_n}, 8'h00);
    rd_reg(8'h1B, rd);
    cmp8(rd, 8'h08);
    idle(2);
    cmp8({7'h0, irq_n}, 8'h01);
    all_ones_alarm <= 8'h04;
    idle(4);
    cmp8({7'h0, irq_n}, 8'h01);
    rd_reg(8'h15, rd);
    cmp8(rd, 8'h00);
    wr_reg(8'h14, 8'hFF);
    all_ones_alarm <= 8'h00;
    idle(2);
    all_ones_alarm <= 8'h04;
    idle(2);
    all_ones_alarm <= 8'h44;
    idle(4);
    cmp8({7'h0, irq_n}, 8'h00);
    rd_reg(8'h15, rd);
    cmp8(rd, 8'h44);
    idle(2);
    cmp8({7'h0, irq_n}, 8'h01);
    rd_reg(8'h15, rd);
    cmp8(rd, 8'h00);
    foreach (rw_addr[k]) wr_reg(rw_addr[k], rw_addr[k] ^ 8'hA5);
    foreach (rw_addr[k]) begin
      rd_reg(rw_addr[k], rd);
      cmp8(rd, rw_addr[k] ^ 8'hA5);
    end
    idle(2);
    cmp8(custom_shape_select, 8'hBC);
    soft_reset <= 1'b1;
    idle(1);
    soft_reset <= 1'b0;
    idle(3);
    foreach (rw_addr[k]) begin
      rd_reg(rw_addr[k], rd);
      cmp8(rd, 8'h00);
    end
    cmp8(custom_shape_select, 8'h00);
    cmp8(img(1, 2), 8'h3F);
    cmp8(img(6, 23), 8'h40);
    close_out();
  end
endmodule : test_pulse_shape_access_alarm_irq
